// File: emb_consts.vh
`ifndef EMB_CONSTS_VH
`define EMB_CONSTS_VH

// Special function register locations
`define EMB_SFR_PORT0      8'h80
`define EMB_SFR_MISC_CTRL  8'h8E
`define EMB_SFR_PORT2      8'hA0
`define EMB_SFR_PORT3      8'hB0

// Field positions
`define EMB_STROBE_OFF_BIT 0
`define EMB_WR_STROBE_BIT  6
`define EMB_RD_STROBE_BIT  7

// Reset values
`define EMB_STROBE_OFF_RST 1'b0
`define EMB_PORT_RST       8'hFF
`define EMB_PIN_HIGH       1'b1
`define EMB_BYTE_ZERO      8'h00
`define EMB_ADDR_ZERO      16'h0000

// Machine cycle timing in oscillator clocks; reset hold length in machine cycles
`define EMB_MC_LAST        4'hB
`define EMB_HALF_LEN       4'h6
`define EMB_HALF_LAST      4'h5
`define EMB_ALE_END        4'h2
`define EMB_ADDR_END       4'h3
`define EMB_PROG_FETCH_STROBE_BEG       4'h3
`define EMB_SAMPLE_POS     4'h5
`define EMB_XD_BEG         4'h3
`define EMB_XD_END         4'hA
`define EMB_XD_SAMPLE      4'h9
`define EMB_MC_CLKS        12
`define EMB_RST_MCS        2

// Machine cycle kinds
`define EMB_CYC_FETCH      1'b0
`define EMB_CYC_XDATA      1'b1

`endif

// File: emb_rst_filter.v
`timescale 1ns/10ps
`include "emb_consts.vh"
`default_nettype none
module emb_rst_filter #(
    parameter CNT_W  = 6,                                 // Counter width
    parameter HOLD_N = `EMB_MC_CLKS * `EMB_RST_MCS        // Clocks the pin must stay high
) (
    input  wire             mclk,      // Oscillator clock
    input  wire             reset_n,   // Asynchronous system reset, active low
    input  wire             rstPin,    // Raw reset pin, active high
    output reg              rstOut     // Filtered core reset, active high
);

    reg             rstMeta;
    reg             rstSync;
    reg [CNT_W-1:0] holdCnt;

    localparam integer     HOLD_LAST_I = HOLD_N - 1;
    localparam [CNT_W-1:0] HOLD_LAST   = HOLD_LAST_I[CNT_W-1:0];

    // Two-stage synchroniser for the reset pin
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            rstMeta <= 1'b0;
            rstSync <= 1'b0;
        end else begin
            rstMeta <= rstPin;
            rstSync <= rstMeta;
        end
    end

    // Reset takes effect only after the pin stays high for two machine cycles
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            holdCnt <= {CNT_W{1'b0}};
            rstOut  <= 1'b1;
        end else if (!rstSync) begin
            holdCnt <= {CNT_W{1'b0}};
            rstOut  <= 1'b0;
        end else if (holdCnt == HOLD_LAST) begin
            rstOut  <= 1'b1;
        end else begin
            holdCnt <= holdCnt + {{(CNT_W-1){1'b0}}, 1'b1};
        end
    end

endmodule // emb_rst_filter
`default_nettype wire

// File: emb_bus_ctrl.v
// How it works
// - Address latch strobe pulses at one sixth of the oscillator rate.
// - An external data access skips exactly one address latch strobe pulse.
// - Setting bit 0 of misc_control at 8Eh stops strobes; pin weakly pulled high.
// - Strobes still appear for data moves, code table reads and external fetches.
// - The strobe off bit has no effect while external execution is selected.
// - Program fetch strobe fires twice per machine cycle during external fetches.
// - In external execution each external data access drops two fetch strobes.
// - Program fetch strobe stays inactive for internal code fetches.
// - Port 0 multiplexes low address and data, driving ones strongly.
// - Port 2 carries high address for external fetches and data pointer accesses.
// - Port 2 keeps its latch value for 8-bit indirect data accesses.
// - With a security bit programmed, access select is captured at reset.
// - Reset pin high for two machine cycles resets the device.
// - Port pins go to reset state at once, asynchronously, on reset pin high.
// - Port 3 bits 6 and 7 serve as external data write and read strobes.
// - A port 0 general I/O bit written with one floats.
// - The strobe off bit clears at reset.
`timescale 1ns/10ps
`include "emb_consts.vh"
`default_nettype none
module emb_bus_ctrl #(
    parameter [15:0] INT_CODE_LAST = 16'h0FFF                  // Highest internal code address
) (
    input  wire        mclk,                // Oscillator clock
    input  wire        reset_n,             // Asynchronous system reset, active low
    input  wire        rstPin,              // Reset pin, active high
    input  wire        extAccessSelect_n,   // Access select pin, low selects external code
    input  wire        securityProg,        // A security bit is programmed
    input  wire [7:0]  sfrAddr,             // Special function register address
    input  wire        sfrWrite,            // Special function register write strobe
    input  wire [7:0]  sfrWdata,            // Special function register write data
    output reg  [7:0]  sfrRdata,            // Special function register read data
    input  wire [15:0] fetchAddr,           // Code address of the next fetch
    input  wire        codeTableReadInstr,  // Next fetch is a code table read
    output reg         codeDone,            // Fetch slot finished, one cycle
    output reg         codeExternal,        // Finished fetch went to external memory
    output reg  [7:0]  codeData,            // Byte read from external code memory
    input  wire        extDataMoveReq,      // External data move requested, level
    input  wire        extDataMoveWrite,    // Data move direction, high writes
    input  wire        useDataPointerReg,   // Data move uses the 16-bit pointer
    input  wire [15:0] extDataMoveAddr,     // Data move address
    input  wire [7:0]  extDataMoveWdata,    // Data move write data
    output reg         extDataMoveDone,     // Data move finished, one cycle
    output reg  [7:0]  extDataMoveRdata,    // Data move read data
    output reg         ale,                 // Address latch strobe, active high
    output reg         aleWeakPull,         // Strobe pin released to weak pullup
    output reg         progFetchStrobe_n,   // Program fetch read strobe, active low
    input  wire [7:0]  p0In,                // Port 0 pin levels
    output reg  [7:0]  p0Out,               // Port 0 output value
    output reg  [7:0]  p0Oe,                // Port 0 output enables
    output reg  [7:0]  p2Out,               // Port 2 output value
    output reg  [7:0]  p3Out,               // Port 3 output value
    output reg         extExecMode,         // External execution in effect
    output reg         coreReset            // Core reset, active high
);

    // Phase decode within a half machine cycle
    function [3:0] halfPos;
        input [3:0] ph;
        begin
            if (ph >= `EMB_HALF_LEN) begin
                halfPos = ph - `EMB_HALF_LEN;
            end else begin
                halfPos = ph;
            end
        end
    endfunction

    wire        rstFilt;
    wire        portClr_n;
    reg         eaMeta;
    reg         eaSync;
    reg         secMeta;
    reg         secSync;
    reg  [7:0]  p0Meta;
    reg  [7:0]  p0Sync;
    reg         eaCaptured;
    reg         latchStrobeOffBit;
    reg  [7:0]  p0Latch;
    reg  [7:0]  p2Latch;
    reg  [7:0]  p3Latch;
    reg  [3:0]  phase;
    reg         cycKind;
    reg         xdWrite;
    reg         xdDptr;
    reg  [15:0] xdAddr;
    reg  [7:0]  xdWdata;
    reg  [15:0] hAddr;
    reg         hExt;
    reg         hAleOn;
    wire [3:0]  hPos;
    wire        eaEffective_n;
    wire        extExec;
    wire        nextExt;
    wire        nextAleOn;
    wire        takeXd;
    reg         codeTake;
    reg         codeTakeExt;
    reg         next_ale;
    reg         next_aleWeakPull;
    reg         next_prog_fetch_strobe_n;
    reg  [7:0]  next_p0Out;
    reg  [7:0]  next_p0Oe;
    reg  [7:0]  next_p2Out;
    reg  [7:0]  next_p3Out;

    emb_rst_filter u_rst_filter (
        .mclk    (mclk),
        .reset_n (reset_n),
        .rstPin  (rstPin),
        .rstOut  (rstFilt)
    );

    // Pin-facing flops clear as soon as the reset pin rises
    // Core state waits for the filtered reset, so a short glitch cannot wipe it
    assign portClr_n = reset_n & ~rstPin;

    // Synchronisers for pins read by the block
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            eaMeta  <= `EMB_PIN_HIGH;
            eaSync  <= `EMB_PIN_HIGH;
            secMeta <= 1'b0;
            secSync <= 1'b0;
            p0Meta  <= `EMB_PORT_RST;
            p0Sync  <= `EMB_PORT_RST;
        end else begin
            eaMeta  <= extAccessSelect_n;
            eaSync  <= eaMeta;
            secMeta <= securityProg;
            secSync <= secMeta;
            p0Meta  <= p0In;
            p0Sync  <= p0Meta;
        end
    end

    // Access select is captured while reset holds the core
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            eaCaptured <= `EMB_PIN_HIGH;
        end else if (rstFilt) begin
            eaCaptured <= eaSync;
        end
    end

    // A programmed security bit freezes the select captured during reset
    assign eaEffective_n = secSync ? eaCaptured : eaSync;
    assign extExec       = ~eaEffective_n;

    // Fetch target and strobe permission for the upcoming half cycle
    assign nextExt   = extExec | (fetchAddr > INT_CODE_LAST);
    assign nextAleOn = nextExt | codeTableReadInstr | extExec | ~latchStrobeOffBit;
    assign hPos      = halfPos(phase);
    assign takeXd    = (phase == `EMB_MC_LAST) && extDataMoveReq && (cycKind == `EMB_CYC_FETCH);

    // Special function register writes and reads
    // Writes are ignored while the core is held in reset
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            latchStrobeOffBit <= `EMB_STROBE_OFF_RST;
            p0Latch           <= `EMB_PORT_RST;
            p2Latch           <= `EMB_PORT_RST;
            p3Latch           <= `EMB_PORT_RST;
            sfrRdata          <= `EMB_BYTE_ZERO;
        end else if (rstFilt) begin
            latchStrobeOffBit <= `EMB_STROBE_OFF_RST;
            p0Latch           <= `EMB_PORT_RST;
            p2Latch           <= `EMB_PORT_RST;
            p3Latch           <= `EMB_PORT_RST;
            sfrRdata          <= `EMB_BYTE_ZERO;
        end else begin
            if (sfrWrite) begin
                if (sfrAddr == `EMB_SFR_MISC_CTRL) begin
                    latchStrobeOffBit <= sfrWdata[`EMB_STROBE_OFF_BIT];
                end else if (sfrAddr == `EMB_SFR_PORT0) begin
                    p0Latch <= sfrWdata;
                end else if (sfrAddr == `EMB_SFR_PORT2) begin
                    p2Latch <= sfrWdata;
                end else if (sfrAddr == `EMB_SFR_PORT3) begin
                    p3Latch <= sfrWdata;
                end
            end
            if (sfrAddr == `EMB_SFR_MISC_CTRL) begin
                sfrRdata <= {7'h00, latchStrobeOffBit};
            end else if (sfrAddr == `EMB_SFR_PORT0) begin
                sfrRdata <= p0Sync;
            end else if (sfrAddr == `EMB_SFR_PORT2) begin
                sfrRdata <= p2Latch;
            end else if (sfrAddr == `EMB_SFR_PORT3) begin
                sfrRdata <= p3Latch;
            end else begin
                sfrRdata <= `EMB_BYTE_ZERO;
            end
        end
    end

    // Machine cycle sequencer: twelve clocks, two fetch halves or one data move
    // A data move replaces a whole machine cycle, so its two fetch halves are lost
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            phase   <= 4'h0;
            cycKind <= `EMB_CYC_FETCH;
            xdWrite <= 1'b0;
            xdDptr  <= 1'b0;
            xdAddr  <= `EMB_ADDR_ZERO;
            xdWdata <= `EMB_BYTE_ZERO;
            hAddr   <= `EMB_ADDR_ZERO;
            hExt    <= 1'b0;
            hAleOn  <= 1'b1;
        end else if (rstFilt) begin
            phase   <= 4'h0;
            cycKind <= `EMB_CYC_FETCH;
            hExt    <= 1'b0;
            hAleOn  <= 1'b1;
        end else begin
            if (phase == `EMB_MC_LAST) begin
                phase <= 4'h0;
            end else begin
                phase <= phase + 4'h1;
            end
            if (hPos == `EMB_HALF_LAST) begin
                hAddr  <= fetchAddr;
                hExt   <= nextExt;
                hAleOn <= nextAleOn;
            end
            if (phase == `EMB_MC_LAST) begin
                cycKind <= takeXd ? `EMB_CYC_XDATA : `EMB_CYC_FETCH;
                xdWrite <= extDataMoveWrite;
                xdDptr  <= useDataPointerReg;
                xdAddr  <= extDataMoveAddr;
                xdWdata <= extDataMoveWdata;
            end
        end
    end

    // Next pin values from cycle kind and phase
    always @* begin
        next_ale         = 1'b0;
        next_aleWeakPull = 1'b0;
        next_prog_fetch_strobe_n      = 1'b1;
        next_p0Out       = `EMB_BYTE_ZERO;
        next_p0Oe        = ~p0Latch;
        next_p2Out       = p2Latch;
        next_p3Out       = p3Latch;
        if (rstFilt) begin
            next_ale    = `EMB_PIN_HIGH;
            next_prog_fetch_strobe_n = `EMB_PIN_HIGH;
            next_p0Oe   = `EMB_BYTE_ZERO;
            next_p2Out  = `EMB_PORT_RST;
            next_p3Out  = `EMB_PORT_RST;
        end else if (cycKind == `EMB_CYC_FETCH) begin
            next_ale         = hAleOn && (hPos < `EMB_ALE_END);
            next_aleWeakPull = ~hAleOn;
            if (hExt) begin
                next_prog_fetch_strobe_n = ~(hPos >= `EMB_PROG_FETCH_STROBE_BEG);
                next_p2Out  = hAddr[15:8];
                if (hPos < `EMB_ADDR_END) begin
                    next_p0Out = hAddr[7:0];
                    next_p0Oe  = 8'hFF;
                end else begin
                    next_p0Oe  = `EMB_BYTE_ZERO;
                end
            end
        end else begin
            // Data move: strobe only in the first half, no fetch strobes
            next_ale = (phase < `EMB_ALE_END);
            next_p2Out = xdDptr ? xdAddr[15:8] : p2Latch;
            if (phase < `EMB_ADDR_END) begin
                next_p0Out = xdAddr[7:0];
                next_p0Oe  = 8'hFF;
            end else if (xdWrite) begin
                next_p0Out = xdWdata;
                next_p0Oe  = 8'hFF;
            end else begin
                next_p0Oe  = `EMB_BYTE_ZERO;
            end
            if ((phase >= `EMB_XD_BEG) && (phase < `EMB_XD_END)) begin
                if (xdWrite) begin
                    next_p3Out[`EMB_WR_STROBE_BIT] = 1'b0;
                end else begin
                    next_p3Out[`EMB_RD_STROBE_BIT] = 1'b0;
                end
            end
        end
    end

    // Pin registers cleared directly by the reset pin
    always @(posedge mclk or negedge portClr_n) begin
        if (!portClr_n) begin
            ale               <= `EMB_PIN_HIGH;
            aleWeakPull       <= 1'b0;
            progFetchStrobe_n <= `EMB_PIN_HIGH;
            p0Out             <= `EMB_BYTE_ZERO;
            p0Oe              <= `EMB_BYTE_ZERO;
            p2Out             <= `EMB_PORT_RST;
            p3Out             <= `EMB_PORT_RST;
        end else begin
            ale               <= next_ale;
            aleWeakPull       <= next_aleWeakPull;
            progFetchStrobe_n <= next_prog_fetch_strobe_n;
            p0Out             <= next_p0Out;
            p0Oe              <= next_p0Oe;
            p2Out             <= next_p2Out;
            p3Out             <= next_p3Out;
        end
    end

    // Completion strobes and captured data toward the core
    // Port 0 reaches p0Sync two clocks late, so a fetched byte is taken one clock
    // after its half ends, while p0Sync still holds the strobed data
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            codeTake         <= 1'b0;
            codeTakeExt      <= 1'b0;
            codeDone         <= 1'b0;
            codeExternal     <= 1'b0;
            codeData         <= `EMB_BYTE_ZERO;
            extDataMoveDone  <= 1'b0;
            extDataMoveRdata <= `EMB_BYTE_ZERO;
            extExecMode      <= 1'b0;
            coreReset        <= 1'b1;
        end else begin
            coreReset   <= rstFilt;
            extExecMode <= extExec;
            codeTake    <= ~rstFilt && (cycKind == `EMB_CYC_FETCH) && (hPos == `EMB_SAMPLE_POS);
            codeDone    <= ~rstFilt && codeTake;
            extDataMoveDone <= ~rstFilt && (cycKind == `EMB_CYC_XDATA) && (phase == `EMB_MC_LAST);
            if ((cycKind == `EMB_CYC_FETCH) && (hPos == `EMB_SAMPLE_POS)) begin
                codeTakeExt <= hExt;
            end
            if (codeTake) begin
                codeExternal <= codeTakeExt;
                codeData     <= codeTakeExt ? p0Sync : `EMB_BYTE_ZERO;
            end
            if ((cycKind == `EMB_CYC_XDATA) && (phase == `EMB_XD_SAMPLE) && !xdWrite) begin
                extDataMoveRdata <= p0Sync;
            end
        end
    end

endmodule // emb_bus_ctrl
`default_nettype wire

// File: emb_bus_ctrl_checker.sv
`timescale 1ns/10ps
`default_nettype none
module emb_bus_ctrl_checker (
    input wire logic       mclk,              // Oscillator clock
    input wire logic       reset_n,           // System reset, active low
    input wire logic       rstPin,            // Reset pin
    input wire logic       ale,               // Latch strobe
    input wire logic       aleWeakPull,       // Strobe pin released
    input wire logic       progFetchStrobe_n, // Fetch strobe, active low
    input wire logic       codeDone,          // Fetch half done
    input wire logic       codeExternal,      // Half went external
    input wire logic       extDataMoveDone,   // Data move done
    input wire logic       extExecMode,       // External execution
    input wire logic       coreReset,         // Core held in reset
    input wire logic [7:0] p0Oe,              // Port 0 enables
    input wire logic [7:0] p2Out,             // Port 2 value
    input wire logic [7:0] p3Out              // Port 3 value
);
    // Pins restart mid-cycle after any reset; give them a machine cycle to settle
    logic [3:0] pinQuiet;
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            pinQuiet <= 4'hC;
        end else if (rstPin) begin
            pinQuiet <= 4'hC;
        end else if (pinQuiet != 4'h0) begin
            pinQuiet <= pinQuiet - 4'h1;
        end
    end

    // Sequencer rules are judged only while the core runs
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n || rstPin || coreReset || (pinQuiet != 4'h0));

    property p_ale_width; $rose(ale) && !aleWeakPull |=> ale ##1 !ale; endproperty
    a_ale_width: assert property (p_ale_width) else $error("strobe width wrong");
    property p_ale_gap; $fell(ale) |-> !ale [*4]; endproperty
    a_ale_gap: assert property (p_ale_gap) else $error("strobe spacing wrong");
    property p_prog_fetch_strobe_width; $fell(progFetchStrobe_n) |-> !progFetchStrobe_n [*3] ##1 progFetchStrobe_n; endproperty
    a_prog_fetch_strobe_width: assert property (p_prog_fetch_strobe_width) else $error("fetch strobe width wrong");
    property p_prog_fetch_strobe_int;
        codeDone && !codeExternal |-> progFetchStrobe_n && $past(progFetchStrobe_n) && $past(progFetchStrobe_n, 2);
    endproperty
    a_prog_fetch_strobe_int: assert property (p_prog_fetch_strobe_int) else $error("fetch strobe in internal half");
    property p_move_quiet; !p3Out[6] || !p3Out[7] |-> !ale && progFetchStrobe_n; endproperty
    a_move_quiet: assert property (p_move_quiet) else $error("strobe during data move");
    property p_rd_width; $fell(p3Out[7]) |-> !p3Out[7] [*7] ##1 p3Out[7] ##[0:4] extDataMoveDone; endproperty
    a_rd_width: assert property (p_rd_width) else $error("read strobe wrong");
    property p_wr_width; $fell(p3Out[6]) |-> !p3Out[6] [*7] ##1 p3Out[6]; endproperty
    a_wr_width: assert property (p_wr_width) else $error("write strobe wrong");
    property p_ext_ale; extExecMode && $past(extExecMode, 8) |-> !aleWeakPull; endproperty
    a_ext_ale: assert property (p_ext_ale) else $error("strobe off in external mode");
    property p_rst_ports;
        disable iff (!reset_n) rstPin |-> ale && progFetchStrobe_n && p0Oe == 8'h00 && p2Out == 8'hFF && p3Out == 8'hFF;
    endproperty
    a_rst_ports: assert property (p_rst_ports) else $error("ports not in reset state");
    property p_core_rst; disable iff (!reset_n) $rose(coreReset) |-> $past(rstPin, 20); endproperty
    a_core_rst: assert property (p_core_rst) else $error("core reset too early");
endmodule // emb_bus_ctrl_checker

bind emb_bus_ctrl emb_bus_ctrl_checker i_chk (.mclk, .reset_n, .rstPin, .ale, .aleWeakPull, .progFetchStrobe_n,
    .codeDone, .codeExternal, .extDataMoveDone, .extExecMode, .coreReset, .p0Oe, .p2Out, .p3Out);
`default_nettype wire

// File: emb_mem_model.sv
`timescale 1ns/10ps
`default_nettype none
module emb_mem_model (
    input  wire logic       mclk,    // Oscillator clock
    input  wire logic       ale,     // Latch strobe
    input  wire logic       prog_fetch_strobe_n,  // Fetch strobe, active low
    input  wire logic [7:0] p0Out,   // Port 0 value
    input  wire logic [7:0] p0Oe,    // Port 0 enables
    input  wire logic [7:0] p2Out,   // High address
    input  wire logic [7:0] p3Out,   // Bit 6 write, bit 7 read
    output var  logic [7:0] p0In     // Port 0 pin level
);
    logic [7:0] addrLo = 8'h00;
    logic [7:0] lastPin = 8'h00;
    logic [7:0] xram [0:255];
    logic [7:0] memData;
    logic       memDrive;

    // Latch keeps the low address once the strobe falls
    always @(negedge ale) addrLo = p0In;
    // Data memory takes the byte as the write strobe ends
    always @(posedge p3Out[6]) xram[addrLo] = p0In;
    // Released lines show the inverse of their last level
    always @(posedge mclk) lastPin <= p0In;
    // Pin level from all drivers of the bus
    always_comb begin
        memDrive = !prog_fetch_strobe_n || !p3Out[7];
        memData  = !prog_fetch_strobe_n ? (p2Out ^ addrLo ^ 8'h5A) : xram[addrLo];
        for (int i = 0; i < 8; i++) begin
            p0In[i] = p0Oe[i] ? p0Out[i] : (memDrive ? memData[i] : ~lastPin[i]);
        end
    end
endmodule // emb_mem_model
`default_nettype wire

// File: external_memory_bus_control_bench.sv
`timescale 1ns/10ps
`default_nettype none
module external_memory_bus_control_bench;
    logic mclk = 0, reset_n = 0, rstPin = 0, accN = 1, secP = 0, sfrWrite = 0, tblRd = 0;
    logic mvReq = 0, mvWr = 0, mvPtr = 0, chkCode = 0, aleQ = 1, psenQ = 1;
    logic [7:0] sfrAddr = 8'h00, sfrWdata = 8'h00, mvWdata = 8'h00, rd, p2Seen;
    logic [15:0] fetchAddr = 16'h0010, mvAddr = 16'h0000;
    wire logic [7:0] sfrRdata, codeData, mvRdata, p0Out, p0Oe, p2Out, p3Out;
    logic [7:0] p0In;
    wire logic codeDone, codeExt, mvDone, ale, aleWeak, psenN, extMode, coreRst;
    int num_errors = 0, cmp_count = 0, cycles = 0, aleRise, psenFall;

    emb_bus_ctrl i_dut (.mclk, .reset_n, .rstPin, .extAccessSelect_n(accN), .securityProg(secP), .sfrAddr,
        .sfrWrite, .sfrWdata, .sfrRdata, .fetchAddr, .codeTableReadInstr(tblRd), .codeDone, .codeExternal(codeExt),
        .codeData, .extDataMoveReq(mvReq), .extDataMoveWrite(mvWr), .useDataPointerReg(mvPtr),
        .extDataMoveAddr(mvAddr), .extDataMoveWdata(mvWdata), .extDataMoveDone(mvDone), .extDataMoveRdata(mvRdata),
        .ale, .aleWeakPull(aleWeak), .progFetchStrobe_n(psenN), .p0In, .p0Out, .p0Oe, .p2Out, .p3Out,
        .extExecMode(extMode), .coreReset(coreRst));
    emb_mem_model i_mem (.mclk, .ale, .prog_fetch_strobe_n(psenN), .p0Out, .p0Oe, .p2Out, .p3Out, .p0In);

    // Clock at 250 MHz
    always #2 mclk = ~mclk;

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish;
        $display("Compares %0d, mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Strobe counters, bus capture and code byte checks
    always @(posedge mclk) begin
        cycles++;
        aleRise += (ale && !aleQ);
        psenFall += (!psenN && psenQ);
        aleQ = ale;
        psenQ = psenN;
        if (!p3Out[6] || !p3Out[7]) p2Seen = p2Out;
        if (chkCode && codeDone && codeExt) check(codeData, fetchAddr[15:8] ^ fetchAddr[7:0] ^ 8'h5A);
        if (cycles == 5000) begin
            num_errors++;
            tally_and_finish;
        end
    end

    task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge mclk) {sfrAddr, sfrWdata, sfrWrite} = {a, d, 1'b1};
        @(negedge mclk) sfrWrite = 0;
        @(negedge mclk);
    endtask
    task automatic sfr_rd(input logic [7:0] a);
        @(negedge mclk) sfrAddr = a;
        @(negedge mclk) rd = sfrRdata;
    endtask
    // Settle for the given number of clocks, then count strobes over eight periods
    task automatic win(input int settle);
        repeat (settle) @(negedge mclk);
        {aleRise, psenFall} = 0;
        repeat (48) @(negedge mclk);
    endtask

    task automatic t_regs;
        sfr_rd(8'h8E); check(rd, 8'h00);
        sfr_rd(8'hA0); check(rd, 8'hFF);
        sfr_rd(8'h55); check(rd, 8'h00);
        $display("test regs done");
    endtask
    task automatic t_internal;
        win(12); check(aleRise, 8); check(psenFall, 0);
        sfr_wr(8'h80, 8'h0F); check(p0Oe, 8'hF0);
        sfr_wr(8'h80, 8'hFF);
        $display("test internal done");
    endtask
    task automatic t_strobe_off;
        sfr_wr(8'h8E, 8'h01); sfr_rd(8'h8E); check(rd, 8'h01);
        win(12); check(aleRise, 0); check(aleWeak, 1);
        tblRd = 1; win(12); check(aleRise, 8); tblRd = 0;
        fetchAddr = 16'h2345; chkCode = 1;
        win(12); check(aleRise, 8); check(psenFall, 8);
        $display("test strobe off done");
    endtask
    task automatic t_ext_exec;
        chkCode = 0; accN = 0; fetchAddr = 16'h0010;
        repeat (12) @(negedge mclk);
        chkCode = 1;
        win(12); check(extMode, 1); check(aleWeak, 0); check(aleRise, 8); check(psenFall, 8);
        $display("test external execution done");
    endtask
    task automatic move(input logic w, input logic ptr, input logic [15:0] a, input logic [7:0] d);
        int n;
        win(12 - 12);
        {aleRise, psenFall, p2Seen} = 0;
        @(negedge mclk) {mvReq, mvWr, mvPtr, mvAddr, mvWdata} = {1'b1, w, ptr, a, d};
        for (n = 1; n < 40 && mvDone !== 1'b1; n++) @(negedge mclk);
        mvReq = 0;
        rd = mvRdata;
        repeat (48 - n) @(negedge mclk);
        check(aleRise, 7); check(psenFall, 6);
    endtask
    task automatic t_moves;
        sfr_wr(8'hA0, 8'h3C);
        move(1, 1, 16'h1234, 8'hA5); check(p2Seen, 8'h12);
        move(0, 0, 16'h0034, 8'h00); check(p2Seen, 8'h3C); check(rd, 8'hA5);
        $display("test data moves done");
    endtask
    task automatic t_reset;
        chkCode = 0;
        @(negedge mclk) rstPin = 1;
        #1 check(p2Out, 8'hFF);
        repeat (10) @(negedge mclk);
        rstPin = 0;
        check(coreRst, 0); sfr_rd(8'h8E); check(rd, 8'h01);
        @(negedge mclk) {secP, rstPin} = 2'b11;
        repeat (40) @(negedge mclk);
        check(coreRst, 1); rstPin = 0;
        repeat (10) @(negedge mclk);
        accN = 1;
        repeat (10) @(negedge mclk);
        check(extMode, 1); sfr_rd(8'h8E); check(rd, 8'h00);
        secP = 0;
        repeat (10) @(negedge mclk);
        check(extMode, 0);
        $display("test reset done");
    endtask

    // Main sequence
    initial begin
        repeat (6) @(negedge mclk);
        reset_n = 1;
        repeat (10) @(negedge mclk);
        t_regs;
        t_internal;
        t_strobe_off;
        t_ext_exec;
        t_moves;
        t_reset;
        tally_and_finish;
    end
endmodule // external_memory_bus_control_bench
`default_nettype wire
